// ---- include/spsp_pkg.sv ----
// Shared constants for the parallel system port
package spsp_pkg;
  localparam int unsigned BYTE_BITS        = 8;
  localparam int unsigned BIT_IDX_W        = 3;
  localparam logic [2:0]  BIT_LAST         = 3'h7;
  localparam logic [2:0]  BIT_HALF_LAST    = 3'h3;
  localparam logic [2:0]  BIT_HALF         = 3'h4;
  localparam int unsigned LINE_RATE_RATIO  = 4;     // 622.08 / 155.52
  localparam int unsigned FAST_BYTE_PS     = 12860; // 12.86 ns byte period
  localparam int unsigned SLOW_BYTE_PS     = 51440; // 51.44 ns byte period
  localparam int unsigned CNT_W            = 8;
  localparam logic [7:0]  BYTE_RESET       = 8'h00;
endpackage

// ---- rtl/spsp_byte_clock_div.sv ----
// Bit-rate tick generator and divide-by-eight byte clock
`timescale 1ns/1ps
module spsp_byte_clock_div
  import spsp_pkg::*;
#(
  parameter int unsigned FAST_BIT_CYCLES = 1
) (
  input  wire logic clk,      // system clock
  input  wire logic rst,      // async reset, active high
  input  wire logic fastMode, // high: four-times rate
  output logic      bitTick,  // one bit time elapsed
  output logic      riseTick, // byte clock rises now
  output logic      fallTick, // byte clock falls now
  output logic      byteClk   // divided byte clock level
);
  localparam int unsigned SLOW_BIT_CYCLES = FAST_BIT_CYCLES * LINE_RATE_RATIO;
  localparam logic [CNT_W-1:0] FAST_LIM = CNT_W'(FAST_BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] SLOW_LIM = CNT_W'(SLOW_BIT_CYCLES - 1);

  typedef struct packed {
    logic [CNT_W-1:0]     cnt;
    logic [BIT_IDX_W-1:0] bitIdx;
    logic                 clkLvl;
  } spsp_div_type;

  spsp_div_type s_q;
  spsp_div_type s_d;

  always_comb begin
    s_d      = s_q;
    bitTick  = (s_q.cnt == '0);
    riseTick = bitTick && (s_q.bitIdx == BIT_LAST);
    fallTick = bitTick && (s_q.bitIdx == BIT_HALF_LAST);
    if (bitTick) begin
      s_d.cnt    = fastMode ? FAST_LIM : SLOW_LIM;
      s_d.bitIdx = s_q.bitIdx + 3'h1;
    end else begin
      s_d.cnt = s_q.cnt - CNT_W'(1);
    end
    // High for bits 0..3, low for 4..7: serial clock over eight
    s_d.clkLvl = (s_d.bitIdx < BIT_HALF);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign byteClk = s_q.clkLvl;
endmodule // spsp_byte_clock_div

// ---- rtl/spsp_system_port.sv ----
// Byte-wide transmit and receive system port of the transceiver
// Operation
// - Serial stream runs four times faster in fast mode than base mode.
// - Transmit byte clock is serial clock over eight, driven to framer.
// - Transmit payload arrives as one byte per transfer on eight bits.
// - Transmit byte captured on rising byte clock edge, either direction.
// - Select low: byte clock pin is input; bus sampled on framer clock.
// - Receive byte clock has nominal byte period of chosen rate.
// - Frame pulse lasts exactly one receive byte clock period.
// - Each new receive byte launched on falling receive clock edge.
// - Serializer sends bit seven first, down to bit zero.
`timescale 1ns/1ps
module spsp_system_port
  import spsp_pkg::*;
#(
  parameter int unsigned FAST_BIT_CYCLES = 1
) (
  input  wire logic                 clk,           // system clock 250 MHz
  input  wire logic                 rst,           // async reset, high
  input  wire logic                 fastModePin,   // high: four-times rate
  input  wire logic                 txClkDirSel,   // high: clock out
  input  wire logic [BYTE_BITS-1:0] txByteIn,      // transmit byte bus
  input  wire logic                 txClkPinIn,    // byte clock pin level
  output logic                      txClkPinOut,   // byte clock drive
  output logic                      txClkPinOe,    // byte clock enable
  output logic                      txSerialOut,   // serial line data
  input  wire logic [BYTE_BITS-1:0] rxByteSipo,    // aligned rx byte
  input  wire logic                 rxByteValid,   // rx byte strobe
  input  wire logic                 rxFrameSipo,   // frame found strobe
  output logic [BYTE_BITS-1:0]      rxByteOut,     // receive byte bus
  output logic                      frameFoundOut, // frame found pulse
  output logic                      rxClkOut       // receive byte clock
);
  typedef struct packed {
    // Two-flop synchronisers for the pins
    logic [1:0]           modeSync;
    logic [1:0]           selSync;
    logic [1:0]           pinClkSync;
    logic                 pinClkLast;
    logic [BYTE_BITS-1:0] dataSync1;
    logic [BYTE_BITS-1:0] dataSync2;

    // Transmit capture and serializer
    logic [BYTE_BITS-1:0] txHold;
    logic [BYTE_BITS-1:0] txShift;
    logic                 txSer;
    logic                 txOe;

    // Receive launch stage
    logic [BYTE_BITS-1:0] rxPend;
    logic                 rxPendFrame;
    logic [BYTE_BITS-1:0] rxOut;
    logic                 rxFrame;
  } spsp_port_type;

  spsp_port_type s_q;
  spsp_port_type s_d;

  logic fastMode;
  logic txBitTick;
  logic txRise;
  logic txByteClk;
  logic rxFall;
  logic rxByteClk;
  logic pinRise;
  logic captureTick;
  logic txLoad;
  logic txShiftOn;
  logic rxLaunch;

  assign fastMode = s_q.modeSync[1];

  spsp_byte_clock_div #(
    .FAST_BIT_CYCLES (FAST_BIT_CYCLES)
  ) u_tx_div (
    .clk      (clk),
    .rst      (rst),
    .fastMode (fastMode),
    .bitTick  (txBitTick),
    .riseTick (txRise),
    .fallTick (),
    .byteClk  (txByteClk)
  );

  spsp_byte_clock_div #(
    .FAST_BIT_CYCLES (FAST_BIT_CYCLES)
  ) u_rx_div (
    .clk      (clk),
    .rst      (rst),
    .fastMode (fastMode),
    .bitTick  (),
    .riseTick (),
    .fallTick (rxFall),
    .byteClk  (rxByteClk)
  );

  always_comb begin
    s_d = s_q;

    // Pin inputs: two flops before any logic reads them
    s_d.modeSync[0]   = fastModePin;
    s_d.modeSync[1]   = s_q.modeSync[0];
    s_d.selSync[0]    = txClkDirSel;
    s_d.selSync[1]    = s_q.selSync[0];
    s_d.pinClkSync[0] = txClkPinIn;
    s_d.pinClkSync[1] = s_q.pinClkSync[0];
    s_d.pinClkLast    = s_q.pinClkSync[1];
    s_d.dataSync1     = txByteIn;
    s_d.dataSync2     = s_q.dataSync1;

    // Framer clock edge, seen only after the synchroniser
    pinRise = s_q.pinClkSync[1] && !s_q.pinClkLast;
    // Data and clock see the same sync delay, so edges stay paired
    captureTick = s_q.selSync[1] ? txRise : pinRise;
    if (captureTick) begin
      s_d.txHold = s_q.dataSync2;
    end

    // Serial framing always runs from the synthesized timing; in input
    // mode a byte is dropped or repeated if the framer clock drifts.
    txLoad    = txBitTick && txRise;
    txShiftOn = txBitTick && !txRise;
    if (txLoad) begin
      // Byte boundary: held byte enters the shifter, MSB goes out first
      s_d.txShift = s_q.txHold;
      s_d.txSer   = s_q.txHold[BYTE_BITS-1];
    end
    if (txShiftOn) begin
      s_d.txShift = {s_q.txShift[BYTE_BITS-2:0], 1'b0};
      s_d.txSer   = s_q.txShift[BYTE_BITS-2];
    end

    // Pin driver follows the synchronised select
    s_d.txOe = s_q.selSync[1];

    // Latest aligned byte waits for the next falling edge
    rxLaunch = rxFall;
    if (rxByteValid) begin
      s_d.rxPend      = rxByteSipo;
      s_d.rxPendFrame = rxFrameSipo;
    end else if (rxLaunch) begin
      // Launched flag is dropped so the pulse lasts one period only
      s_d.rxPendFrame = 1'b0;
    end
    if (rxLaunch) begin
      s_d.rxOut   = s_q.rxPend;
      s_d.rxFrame = s_q.rxPendFrame;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Byte clocks come straight from the divider flops, so each edge
  // lines up with the capture and launch ticks of the same cycle
  assign txClkPinOut   = txByteClk;
  assign txClkPinOe    = s_q.txOe;
  assign txSerialOut   = s_q.txSer;
  assign rxByteOut     = s_q.rxOut;
  assign frameFoundOut = s_q.rxFrame;
  assign rxClkOut      = rxByteClk;
endmodule // spsp_system_port

// ---- bench/spsp_system_port_properties.sv ----
// Pin timing checks for the system port
`timescale 1ns/1ps
module spsp_port_checker #(
  parameter int unsigned FAST_BIT_CYCLES = 1
) (
  input wire logic       clk,          // clock
  input wire logic       rst,          // reset
  input wire logic       fastModePin,  // rate
  input wire logic       txClkDirSel,  // direction
  input wire logic       txClkPinOe,   // enable
  input wire logic       txClkPinOut,  // tx clock
  input wire logic       rxClkOut,     // rx clock
  input wire logic [7:0] rxByteOut,    // rx byte
  input wire logic       frameFoundOut // frame
);
  localparam int FB = 8 * FAST_BIT_CYCLES;
  localparam int SB = 32 * FAST_BIT_CYCLES;
  logic [4:0] age_q;
  // Rate pin is synced, so periods settle late
  always_ff @(posedge clk or posedge rst)
    if (rst) age_q <= 5'h00;
    else if (!age_q[4]) age_q <= age_q + 5'h01;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  oe_drive_a: assert property ($rose(txClkDirSel) |-> ##[1:4] txClkPinOe)
    else $error("clock pin not driven");
  oe_release_a: assert property ($fell(txClkDirSel) |-> ##[1:4] !txClkPinOe)
    else $error("clock pin not released");
  tx_fast_a: assert property (age_q[4] && fastModePin && txClkPinOe && $rose(txClkPinOut) |-> ##FB ($rose(txClkPinOut) || !txClkPinOe))
    else $error("fast tx clock period");
  tx_base_a: assert property (age_q[4] && !fastModePin && txClkPinOe && $rose(txClkPinOut) |-> ##SB ($rose(txClkPinOut) || !txClkPinOe))
    else $error("base tx clock period");
  rx_fast_a: assert property (age_q[4] && fastModePin && $rose(rxClkOut) |-> rxClkOut[*4] ##1 !rxClkOut)
    else $error("fast rx clock shape");
  rx_base_a: assert property (age_q[4] && !fastModePin && $rose(rxClkOut) |-> ##SB $rose(rxClkOut))
    else $error("base rx clock period");
  rx_launch_a: assert property ($changed(rxByteOut) |-> $fell(rxClkOut))
    else $error("rx byte off falling edge");
  frame_width_a: assert property (age_q[4] && fastModePin && $rose(frameFoundOut) |-> frameFoundOut[*8] ##1 !frameFoundOut)
    else $error("frame pulse width");
  cover property ($fell(txClkPinOe));
  cover property ($rose(frameFoundOut));
  cover property (!fastModePin && $rose(rxClkOut));
endmodule // spsp_port_checker
bind spsp_system_port spsp_port_checker #(.FAST_BIT_CYCLES(FAST_BIT_CYCLES))
  u_spsp_port_checker (.clk(clk), .rst(rst), .fastModePin(fastModePin),
  .txClkDirSel(txClkDirSel), .txClkPinOe(txClkPinOe),
  .txClkPinOut(txClkPinOut), .rxClkOut(rxClkOut), .rxByteOut(rxByteOut),
  .frameFoundOut(frameFoundOut));

// ---- bench/spsp_framer_model.sv ----
// Behavioural framer on the byte bus
`timescale 1ns/1ps
module spsp_framer_model #(
  parameter int HALF = 4
) (
  input wire logic       clk,           // clock
  input wire logic       own,           // framer sources clock
  input wire logic       pin,           // clock wire
  input wire logic       rxClk,         // rx clock
  input wire logic [7:0] rxByte,        // rx byte
  output logic           fclk = 1'b0,   // clock drive
  output logic [7:0]     txByte = 8'h00, // tx byte
  output logic [7:0]     rxSeen = 8'h00  // rx byte taken
);
  int   cnt = 0;
  logic last = 1'b0;
  always @(negedge clk) begin
    // Idle drive toggles so a stale level cannot pass
    if (!own || cnt == HALF - 1) fclk <= ~fclk;
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (last && !pin) txByte <= txByte + 8'h11;
    last <= pin;
  end
  always @(posedge rxClk) rxSeen <= rxByte;
endmodule // spsp_framer_model

// ---- bench/tb_spsp_system_port.sv ----
// Self-checking bench for the system port
`timescale 1ns/1ps
module tb_spsp_system_port;
  logic clk = 1'b0, rst = 1'b1, fast = 1'b1, sel = 1'b1, own = 1'b0;
  logic rxVal = 1'b0, rxFr = 1'b0, pOut, pOe, fclk, ser, frame, rxClk;
  logic [7:0] rxIn = 8'h00, txByte, rxSeen, rxOut;
  logic [15:0] sh = 16'h0000;
  int n_mismatch = 0, compares = 0;
  wire pin = pOe ? pOut : fclk;
  initial forever #2 clk = ~clk;
  always @(posedge clk) sh <= {sh[14:0], ser};
  spsp_system_port u_spsp_system_port (.clk(clk), .rst(rst),
    .fastModePin(fast), .txClkDirSel(sel), .txByteIn(txByte),
    .txClkPinIn(pin), .txClkPinOut(pOut), .txClkPinOe(pOe),
    .txSerialOut(ser), .rxByteSipo(rxIn), .rxByteValid(rxVal),
    .rxFrameSipo(rxFr), .rxByteOut(rxOut), .frameFoundOut(frame),
    .rxClkOut(rxClk));
  spsp_framer_model u_spsp_framer_model (.clk(clk), .own(own), .pin(pin),
    .rxClk(rxClk), .rxByte(rxOut), .fclk(fclk), .txByte(txByte),
    .rxSeen(rxSeen));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Two whole bytes back to back, so bit order and capture both show
  task automatic find_tx(input logic [15:0] pat);
    int i;
    for (i = 0; i < 300 && sh !== pat; i++) @(negedge clk);
    chk(sh, pat);
    if (sh !== pat) tally_and_finish();
  endtask
  task automatic rx_one(input logic [7:0] b, input logic f);
    int i;
    @(negedge clk);
    {rxIn, rxVal, rxFr} = {b, 1'b1, f};
    @(negedge clk);
    {rxVal, rxFr} = 2'h0;
    for (i = 0; i < 90 && rxSeen !== b; i++) @(negedge clk);
    chk(rxSeen, b);
    chk(frame, f);
    if (rxSeen !== b) tally_and_finish();
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    find_tx(16'h3344);
    rx_one(8'ha5, 1'b1);
    rx_one(8'h5a, 1'b0);
    {sel, own} = 2'h1;
    repeat (8) @(negedge clk);
    chk(pOe, 1'b0);
    find_tx(16'h6677);
    {sel, own} = 2'h2;
    repeat (8) @(negedge clk);
    chk(pOe, 1'b1);
    {rst, fast, sel, own} = 4'ha;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rx_one(8'hc3, 1'b1);
    repeat (100) @(negedge clk);
    tally_and_finish();
  end
endmodule // tb_spsp_system_port
